// [hw/ddl_lane.sv]
// data lane, strobe, mask, inversion and alert logic of the memory
`timescale 1ns/1ps
`default_nettype none
module ddl_lane (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // mode settings and command side
  input wire ddl_pkg::ddl_cfg_s CFG_I,
  input wire logic WR_START_I,
  input wire logic RD_START_I,
  input wire logic [63:0] RD_DATA_I,
  input wire logic PAR_ERR_I,
  input wire logic ODT_I,
  input wire logic [3:0] VREF_CODE_I,
  // data lanes
  input wire logic [7:0] DQ_I,
  output logic [7:0] DQ_O,
  output logic [7:0] DQ_OE_O,
  // strobe pair
  input wire logic DQS_T_I,
  input wire logic DQS_C_I,
  output logic DQS_T_O,
  output logic DQS_C_O,
  output logic DQS_OE_O,
  // inversion flag lane
  input wire logic INV_FLAG_N_I,
  output logic INV_FLAG_N_O,
  output logic INV_FLAG_OE_O,
  // write mask and termination
  input wire logic WR_MASK_N_I,
  output logic TERM_DQS_O,
  output logic TERM_STROBE_O,
  // write data to core
  output logic [63:0] WR_DATA_O,
  output logic [7:0] WR_KEEP_O,
  output logic WR_VALID_O,
  output logic WR_CRC_ERR_O,
  // status
  output logic ALERT_N_O,
  output logic TRAIN_SLOW_O
);

  // count of zero bits in a byte
  function automatic logic [3:0] zero_cnt(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) n = n + {3'b000, ~b[i]};
    return n;
  endfunction

  // checksum over a whole burst word
  function automatic logic [7:0] crc8(input logic [63:0] d);
    logic [7:0] c;
    c = ddl_pkg::CRC_INIT;
    for (int i = 63; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? ddl_pkg::CRC_POLY : 8'h00);
    return c;
  endfunction

  ddl_pkg::ddl_pin_s pin_w, s1_q, s2_q;
  logic st_q, st_d, diff_ok, wr_edge, mask_on;
  logic [7:0] beat;
  ddl_pkg::ddl_wr_e wst_q, wst_d;
  logic [2:0] wcnt_q, wcnt_d;
  logic [63:0] wdat_q, wdat_d;
  logic [7:0] wkeep_q, wkeep_d, rsum_q, rsum_d, sum;
  logic wvld_q, wvld_d, cerr_q, cerr_d;
  ddl_pkg::ddl_rd_e rst_q, rst_d;
  logic [2:0] rcnt_q, rcnt_d;
  logic [63:0] rdat_q, rdat_d;
  logic [4:0] dcnt_q, dcnt_d;
  logic beat_en, flip;
  logic [7:0] rbyte, dq_q, dq_d, dqoe_q, dqoe_d;
  logic dqs_t_q, dqs_t_d, dqs_c_q, dqs_c_d, dqs_oe_q, dqs_oe_d;
  logic inv_q, inv_d, invoe_q, invoe_d;
  logic [3:0] acnt_q, acnt_d;
  logic err_w, alert_n_q, alert_n_d;
  logic tdqs_q, tdqs_d, tts_q, tts_d, slow_q, slow_d;
  logic [3:0] tog_q;

  // pin bundle into the two-stage synchroniser
  always_comb pin_w = '{dq: DQ_I, inv_n: INV_FLAG_N_I,
    mask_n: WR_MASK_N_I, t: DQS_T_I, c: DQS_C_I};

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= pin_w;
      s2_q <= s1_q;
    end
  end

  // strobe edges count only while the pair is complementary
  always_comb
  begin
    diff_ok = s2_q.t ^ s2_q.c;
    st_d = diff_ok ? s2_q.t : st_q;
    wr_edge = diff_ok && (s2_q.t != st_q) && !dqs_oe_q;
    mask_on = CFG_I.wide && !CFG_I.tdqs_en;
    if (CFG_I.wide)
      beat = (CFG_I.wr_inv && !s2_q.inv_n) ? ~s2_q.dq : s2_q.dq;
    else
      beat = {4'h0, s2_q.dq[3:0]};
  end

  // write burst capture and checksum compare
  always_comb
  begin
    wst_d = wst_q;
    wcnt_d = wcnt_q;
    wdat_d = wdat_q;
    wkeep_d = wkeep_q;
    rsum_d = rsum_q;
    wvld_d = 1'b0;
    cerr_d = 1'b0;
    sum = CFG_I.wide ? rsum_q : {beat[3:0], rsum_q[3:0]};
    unique case (wst_q)
      ddl_pkg::WR_IDLE:
        if (WR_START_I)
        begin
          wst_d = ddl_pkg::WR_DATA;
          wcnt_d = 3'h0;
        end
      ddl_pkg::WR_DATA:
        if (wr_edge)
        begin
          wdat_d[{wcnt_q, 3'b000} +: 8] = beat;
          wkeep_d[wcnt_q] = !(mask_on && !s2_q.mask_n);
          wcnt_d = wcnt_q + 3'h1;
          if (wcnt_q == ddl_pkg::LAST_BEAT)
          begin
            if (CFG_I.crc_en)
              wst_d = ddl_pkg::WR_SUM;
            else
            begin
              wst_d = ddl_pkg::WR_IDLE;
              wvld_d = 1'b1;
            end
          end
        end
      ddl_pkg::WR_SUM:
        if (wr_edge)
        begin
          wcnt_d = wcnt_q + 3'h1;
          if (wcnt_q == 3'h0)
            rsum_d = beat;
          else
          begin
            wst_d = ddl_pkg::WR_IDLE;
            wvld_d = 1'b1;
            cerr_d = (sum != crc8(wdat_q));
          end
        end
      default: wst_d = ddl_pkg::WR_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      st_q <= 1'b0;
      wst_q <= ddl_pkg::WR_IDLE;
      wcnt_q <= 3'h0;
      wdat_q <= '0;
      wkeep_q <= '0;
      rsum_q <= '0;
      wvld_q <= 1'b0;
      cerr_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      wst_q <= wst_d;
      wcnt_q <= wcnt_d;
      wdat_q <= wdat_d;
      wkeep_q <= wkeep_d;
      rsum_q <= rsum_d;
      wvld_q <= wvld_d;
      cerr_q <= cerr_d;
    end
  end

  // read burst: preamble beat, then data with a strobe toggle per beat
  always_comb
  begin
    beat_en = (dcnt_q == 5'(ddl_pkg::BEAT_CYC - 1));
    dcnt_d = (rst_q == ddl_pkg::RD_IDLE || beat_en) ? 5'h0 : dcnt_q + 5'h1;
    rst_d = rst_q;
    rcnt_d = rcnt_q;
    rdat_d = rdat_q;
    dq_d = dq_q;
    dqoe_d = dqoe_q;
    dqs_t_d = dqs_t_q;
    dqs_oe_d = dqs_oe_q;
    inv_d = inv_q;
    invoe_d = invoe_q;
    rbyte = rdat_q[{rcnt_q, 3'b000} +: 8];
    flip = CFG_I.wide && CFG_I.rd_inv &&
      (zero_cnt(rbyte) > ddl_pkg::INV_ZERO_LIM);
    unique case (rst_q)
      ddl_pkg::RD_IDLE:
      begin
        dqs_oe_d = 1'b0;
        dqs_t_d = 1'b0;
        invoe_d = 1'b0;
        dq_d = {4'h0, VREF_CODE_I};
        dqoe_d = CFG_I.vref_mon ? ddl_pkg::LANES_NARROW : 8'h00;
        if (RD_START_I)
        begin
          rst_d = ddl_pkg::RD_PRE;
          rdat_d = RD_DATA_I;
          rcnt_d = 3'h0;
          dqs_oe_d = 1'b1;
          dqoe_d = 8'h00;
        end
      end
      ddl_pkg::RD_PRE, ddl_pkg::RD_BURST:
        if (beat_en)
        begin
          if (rst_q == ddl_pkg::RD_BURST && rcnt_q == 3'h0)
          begin
            rst_d = ddl_pkg::RD_IDLE;
            dqs_oe_d = 1'b0;
            dqoe_d = 8'h00;
            invoe_d = 1'b0;
          end
          else
          begin
            rst_d = ddl_pkg::RD_BURST;
            rcnt_d = rcnt_q + 3'h1;
            dqs_t_d = !dqs_t_q;
            if (CFG_I.wide)
            begin
              dq_d = flip ? ~rbyte : rbyte;
              dqoe_d = ddl_pkg::LANES_WIDE;
            end
            else
            begin
              dq_d = {4'h0, rbyte[3:0]};
              dqoe_d = ddl_pkg::LANES_NARROW;
            end
            inv_d = !flip;
            invoe_d = CFG_I.wide && CFG_I.rd_inv;
          end
        end
      default: rst_d = ddl_pkg::RD_IDLE;
    endcase
    dqs_c_d = !dqs_t_d;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rst_q <= ddl_pkg::RD_IDLE;
      rcnt_q <= 3'h0;
      rdat_q <= '0;
      dcnt_q <= 5'h0;
      dq_q <= 8'h00;
      dqoe_q <= 8'h00;
      dqs_t_q <= 1'b0;
      dqs_c_q <= 1'b1;
      dqs_oe_q <= 1'b0;
      inv_q <= 1'b1;
      invoe_q <= 1'b0;
    end
    else
    begin
      rst_q <= rst_d;
      rcnt_q <= rcnt_d;
      rdat_q <= rdat_d;
      dcnt_q <= dcnt_d;
      dq_q <= dq_d;
      dqoe_q <= dqoe_d;
      dqs_t_q <= dqs_t_d;
      dqs_c_q <= dqs_c_d;
      dqs_oe_q <= dqs_oe_d;
      inv_q <= inv_d;
      invoe_q <= invoe_d;
    end
  end

  // alert hold, termination and status
  always_comb
  begin
    err_w = (PAR_ERR_I && CFG_I.par_en) || cerr_q;
    if (err_w)
      acnt_d = ddl_pkg::ALERT_CYC;
    else
      acnt_d = (acnt_q != 4'h0) ? acnt_q - 4'h1 : 4'h0;
    alert_n_d = (acnt_d == 4'h0);
    tdqs_d = ODT_I && !dqs_oe_d;
    tts_d = tdqs_d && CFG_I.wide && CFG_I.tdqs_en;
    slow_d = CFG_I.vref_mon;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      acnt_q <= 4'h0;
      alert_n_q <= 1'b1;
      tdqs_q <= 1'b0;
      tts_q <= 1'b0;
      slow_q <= 1'b0;
    end
    else
    begin
      acnt_q <= acnt_d;
      alert_n_q <= alert_n_d;
      tdqs_q <= tdqs_d;
      tts_q <= tts_d;
      slow_q <= slow_d;
    end
  end

  // outputs
  assign DQ_O = dq_q;
  assign DQ_OE_O = dqoe_q;
  assign DQS_T_O = dqs_t_q;
  assign DQS_C_O = dqs_c_q;
  assign DQS_OE_O = dqs_oe_q;
  assign INV_FLAG_N_O = inv_q;
  assign INV_FLAG_OE_O = invoe_q;
  assign TERM_DQS_O = tdqs_q;
  assign TERM_STROBE_O = tts_q;
  assign WR_DATA_O = wdat_q;
  assign WR_KEEP_O = wkeep_q;
  assign WR_VALID_O = wvld_q;
  assign WR_CRC_ERR_O = cerr_q;
  assign ALERT_N_O = alert_n_q;
  assign TRAIN_SLOW_O = slow_q;

  // strobe toggle counter watched by the burst length check
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      tog_q <= 4'h0;
    else if (!dqs_oe_q)
      tog_q <= 4'h0;
    else if (dqs_t_d != dqs_t_q)
      tog_q <= tog_q + 4'h1;
  end

  // checks
  narrow_lanes_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    DQ_OE_O[7:4] != 4'h0 |-> $past(CFG_I.wide))
    else $error("upper lanes driven in narrow mode");
  inv_lane_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    INV_FLAG_OE_O |-> $past(CFG_I.wide && CFG_I.rd_inv))
    else $error("inversion lane driven when not enabled");
  strobe_dir_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    RD_START_I && rst_q == ddl_pkg::RD_IDLE |=> DQS_OE_O && !DQS_T_O)
    else $error("strobe not driven after read start");
  strobe_diff_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    DQS_OE_O |-> DQS_T_O != DQS_C_O)
    else $error("strobe pair not complementary");
  edge_align_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $past(DQS_OE_O) && DQS_OE_O && $changed(DQ_O) |-> $changed(DQS_T_O))
    else $error("read data moved without strobe edge");
  burst_len_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $fell(DQS_OE_O) |-> tog_q == 4'h8)
    else $error("read burst not eight beats");
  vref_mon_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CFG_I.vref_mon && rst_q == ddl_pkg::RD_IDLE && !RD_START_I
    |=> DQ_OE_O == 8'h0f && DQ_O[3:0] == $past(VREF_CODE_I))
    else $error("reference level not on low lanes");
  alert_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    PAR_ERR_I && CFG_I.par_en |=> !ALERT_N_O [*8])
    else $error("alert not held for parity error");
  alert_quiet_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    acnt_q <= 4'h1 && !err_w |=> ALERT_N_O)
    else $error("alert low without error");
  term_strobe_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    TERM_STROBE_O |-> TERM_DQS_O && $past(CFG_I.wide && CFG_I.tdqs_en))
    else $error("termination strobe mismatch");
  mask_drop_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    wst_q == ddl_pkg::WR_DATA && wr_edge && mask_on && !s2_q.mask_n
    |=> !wkeep_q[$past(wcnt_q)])
    else $error("masked beat kept");
  crc_phase_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    wst_q == ddl_pkg::WR_DATA && wr_edge && wcnt_q == 3'h7 && CFG_I.crc_en
    |=> wst_q == ddl_pkg::WR_SUM && !WR_VALID_O)
    else $error("checksum beats not expected");

endmodule // ddl_lane
`default_nettype wire

// [include/ddl_pkg.sv]
// constants, types and mode bundle for the ddr data lane block
package ddl_pkg;
  // clock and beat timing
  localparam int CLK_PS = 5000;
  localparam int BEAT_PS = 80000;
  localparam int BEAT_CYC = (BEAT_PS + CLK_PS - 1) / CLK_PS;
  // burst shape
  localparam int BURST_LEN = 8;
  localparam logic [2:0] LAST_BEAT = 3'(BURST_LEN - 1);
  localparam int DQ_W = 8;
  localparam int WORD_W = DQ_W * BURST_LEN;
  localparam logic [7:0] LANES_WIDE = 8'hff;
  localparam logic [7:0] LANES_NARROW = 8'h0f;
  localparam logic [3:0] INV_ZERO_LIM = 4'h4;
  // write checksum
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hff;
  // alert hold length
  localparam logic [3:0] ALERT_CYC = 4'h8;
  // state machines
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_DATA = 2'b01,
    WR_SUM = 2'b10
  } ddl_wr_e;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_PRE = 2'b01,
    RD_BURST = 2'b10
  } ddl_rd_e;
  // mode settings
  typedef struct packed {
    logic wide;
    logic crc_en;
    logic rd_inv;
    logic wr_inv;
    logic tdqs_en;
    logic par_en;
    logic vref_mon;
  } ddl_cfg_s;
  // sampled pin bundle
  typedef struct packed {
    logic [7:0] dq;
    logic inv_n;
    logic mask_n;
    logic t;
    logic c;
  } ddl_pin_s;
endpackage

// [tb/ddl_host_model.sv]
// controller-side model that drives write bursts onto the lanes
`timescale 1ns/1ps
`default_nettype none
module ddl_host_model (
  // clock
  input wire logic clk_i,
  // controller pins
  output logic start_o,
  output logic [7:0] dq_o,
  output logic t_o,
  output logic c_o,
  output logic inv_n_o,
  output logic mask_n_o
);
  // idle levels at time zero
  initial
  begin
    start_o = 1'h0;
    dq_o = 8'h00;
    {t_o, c_o, inv_n_o, mask_n_o} = 4'h7;
  end
  // n beats of p with mask m and flag v; strobe edge mid eye
  task automatic burst(input logic [79:0] p, input logic [9:0] m, v,
    input int n);
    @(negedge clk_i);
    {t_o, c_o} = 2'h1;
    repeat (4) @(negedge clk_i);
    start_o = 1'h1;
    @(negedge clk_i);
    start_o = 1'h0;
    for (int k = 0; k < n; k++)
    begin
      dq_o = p[8*k+:8];
      mask_n_o = m[k];
      inv_n_o = v[k];
      repeat (8) @(negedge clk_i);
      {t_o, c_o} = {~t_o, t_o};
      repeat (8) @(negedge clk_i);
    end
    // released lines show the inverse of the last level
    {dq_o, inv_n_o, mask_n_o} = ~{dq_o, inv_n_o, mask_n_o};
    {t_o, c_o} = {c_o, t_o};
  endtask
endmodule // ddl_host_model
`default_nettype wire

// [tb/ddl_lane_tb_top.sv]
// self-checking bench for the ddr data lane block
`timescale 1ns/1ps
`default_nettype none
module ddl_lane_tb_top;
  logic clk_i;
  logic rst_n;
  ddl_pkg::ddl_cfg_s cfg;
  logic rd_start, par_err, odt;
  logic [63:0] rd_data, wr_data;
  logic [3:0] vref;
  logic [7:0] dq_o, dq_oe, h_dq, dq_w, wr_keep;
  logic dqs_t, dqs_c, dqs_oe, inv_o, inv_oe, term_d, term_s;
  logic h_start, h_t, h_c, h_inv, h_mask, t_w, c_w, inv_w;
  logic wr_valid, crc_err, alert_n, slow;
  int miscompares, comparisons;
  logic [7:0] cn;
  logic [63:0] d = 64'h0123_4567_89ab_cdef;
  // wire levels chosen by the lane block's enables
  assign dq_w = (dq_oe & dq_o) | (~dq_oe & h_dq);
  assign t_w = dqs_oe ? dqs_t : h_t;
  assign c_w = dqs_oe ? dqs_c : h_c;
  assign inv_w = inv_oe ? inv_o : h_inv;
  ddl_lane ddl_lane_i (.CLK_I(clk_i), .RST_N_I(rst_n), .CFG_I(cfg),
    .WR_START_I(h_start), .RD_START_I(rd_start), .RD_DATA_I(rd_data),
    .PAR_ERR_I(par_err), .ODT_I(odt), .VREF_CODE_I(vref), .DQ_I(dq_w),
    .DQ_O(dq_o), .DQ_OE_O(dq_oe), .DQS_T_I(t_w), .DQS_C_I(c_w),
    .DQS_T_O(dqs_t), .DQS_C_O(dqs_c), .DQS_OE_O(dqs_oe),
    .INV_FLAG_N_I(inv_w), .INV_FLAG_N_O(inv_o), .INV_FLAG_OE_O(inv_oe),
    .WR_MASK_N_I(h_mask), .TERM_DQS_O(term_d), .TERM_STROBE_O(term_s),
    .WR_DATA_O(wr_data), .WR_KEEP_O(wr_keep), .WR_VALID_O(wr_valid),
    .WR_CRC_ERR_O(crc_err), .ALERT_N_O(alert_n), .TRAIN_SLOW_O(slow));
  ddl_host_model ddl_host_model_i (.clk_i(clk_i), .start_o(h_start),
    .dq_o(h_dq), .t_o(h_t), .c_o(h_c), .inv_n_o(h_inv),
    .mask_n_o(h_mask));
  // 200 MHz clock
  initial
  begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  // compare and count
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic print_verdict();
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // checksum over the captured burst, msb first
  function automatic logic [7:0] crc8(input logic [63:0] w);
    logic [7:0] c;
    c = ddl_pkg::CRC_INIT;
    for (int i = 63; i >= 0; i--)
      c = {c[6:0], 1'h0} ^ ((c[7] ^ w[i]) ? ddl_pkg::CRC_POLY : 8'h00);
    return c;
  endfunction
  // alert low for eight cycles starting at this edge, then released
  task automatic alert_hold();
    repeat (8)
    begin
      chk(alert_n, 1'h0);
      @(negedge clk_i);
    end
    chk(alert_n, 1'h1);
  endtask
  // one write burst; checks data, keep bits and checksum flag
  task automatic wr(input logic [79:0] p, input logic [9:0] m, v,
    input int n, input logic [63:0] e, s, input logic [7:0] kp,
    input logic er);
    fork
      ddl_host_model_i.burst(p, m, v, n);
      begin
        for (int i = 0; i < 400 && wr_valid !== 1'h1; i++)
          @(negedge clk_i);
        chk({wr_valid, wr_data & s, wr_keep, crc_err}, {1'h1, e & s, kp, er});
        // checksum alert starts one cycle after the error pulse
        if (er)
        begin
          @(negedge clk_i);
          alert_hold();
        end
      end
    join
  endtask
  // read burst in wide or narrow mode
  task automatic rd(input logic w);
    logic [7:0] b;
    logic i;
    @(negedge clk_i);
    rd_start = 1'h1;
    @(negedge clk_i);
    rd_start = 1'h0;
    @(negedge clk_i);
    chk({dqs_oe, t_w, c_w, term_d}, 4'ha);
    for (int k = 0; k < 8; k++)
    begin
      repeat (16) @(negedge clk_i);
      b = rd_data[8*k+:8];
      i = w && ($countones(b) < 4);
      b = w ? (i ? ~b : b) : b & 8'h0f;
      chk({dq_oe, dq_w & dq_oe, inv_oe, inv_w | ~inv_oe, t_w, c_w},
        {w ? 8'hff : 8'h0f, b, w, ~i, ~k[0], k[0]});
    end
    repeat (16) @(negedge clk_i);
    chk({dqs_oe, dq_oe}, 9'h000);
  endtask
  // command parity pulse
  task automatic perr();
    @(negedge clk_i);
    par_err = 1'h1;
    @(negedge clk_i);
    par_err = 1'h0;
  endtask
  // reference level shown on the low lanes
  task automatic vmon();
    cfg = 7'h41;
    odt = 1'h0;
    vref = 4'ha;
    repeat (2) @(negedge clk_i);
    chk({dq_oe, dq_w[3:0], slow}, 13'h01f5);
    vref = 4'h5;
    repeat (2) @(negedge clk_i);
    chk({dq_oe, dq_w[3:0], slow}, 13'h01eb);
    cfg = 7'h40;
    repeat (2) @(negedge clk_i);
    chk({dq_oe, slow}, 9'h000);
  endtask
  // reset, then each scenario in turn
  initial
  begin
    rst_n = 1'h0;
    cfg = 7'h00;
    rd_start = 1'h0;
    par_err = 1'h0;
    odt = 1'h0;
    vref = 4'h0;
    rd_data = 64'h8001_7f0f_fe10_ff00;
    repeat (20) @(negedge clk_i);
    chk({dqs_oe, dq_oe, inv_oe, alert_n}, 11'h001);
    rst_n = 1'h1;
    cfg = 7'h48;
    wr({16'h0000, d ^ 64'h0000_0000_0000_ff00}, 10'h3f7, 10'h3fd, 8, d,
      64'hffff_ffff_00ff_ffff, 8'hf7, 1'h0);
    cfg = 7'h44;
    odt = 1'h1;
    wr({16'h0000, d}, 10'h3f7, 10'h3fd, 8, d, '1, 8'hff, 1'h0);
    chk({term_d, term_s}, 2'h3);
    cfg = 7'h48;
    repeat (2) @(negedge clk_i);
    chk({term_d, term_s}, 2'h2);
    cfg = 7'h08;
    wr({16'h0000, d}, 10'h3f7, 10'h3fd, 8, d & {8{8'h0f}}, '1, 8'hff,
      1'h0);
    // narrow checksum: low nibble first, then high nibble
    cfg = 7'h20;
    cn = crc8(d & {8{8'h0f}});
    wr({4'h0, cn[7:4], 4'h0, cn[3:0], d}, '1, '1, 10, d & {8{8'h0f}}, '1,
      8'hff, 1'h0);
    cfg = 7'h62;
    wr({8'h00, crc8(d), d}, '1, '1, 10, d, '1, 8'hff, 1'h0);
    wr({8'h00, crc8(d) ^ 8'h01, d}, '1, '1, 10, d, '1, 8'hff,
      1'h1);
    cfg = 7'h50;
    rd(1'h1);
    cfg = 7'h10;
    rd(1'h0);
    cfg = 7'h40;
    perr();
    @(negedge clk_i);
    chk(alert_n, 1'h1);
    cfg = 7'h42;
    perr();
    alert_hold();
    vmon();
    print_verdict();
  end
  // watchdog: the tests need about 1240 cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    print_verdict();
  end
endmodule // ddl_lane_tb_top
`default_nettype wire
